// [verilog/vidmap_pkg.sv]
// Purpose: shared constants for the video memory map, pixel unpacker and panel power sequencer
// Assumes: 24-bit system bus addresses, 15-bit video SRAM address
// Notes:   registers sit on a plain strobe port, one word per index
package vidmap_pkg;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam logic [23:0] COLOR_WIN_BASE   = 24'h0B8000;
  localparam logic [23:0] COLOR_WIN_LAST   = 24'h0BFFFF;
  localparam logic [23:0] MONO_WIN_BASE    = 24'h0B0000;
  localparam logic [23:0] MONO_WIN_LAST    = 24'h0B7FFF;
  localparam int          SRAM_ADDR_W      = 15;

  // ----------------------------------------------------------------
  // graphics layout
  // ----------------------------------------------------------------
  localparam logic [14:0] BANK_SIZE        = 15'h2000;
  localparam logic [7:0]  BYTES_ROW_640    = 8'h50;
  localparam logic [7:0]  BYTES_ROW_480    = 8'h3C;

  // ----------------------------------------------------------------
  // register indices and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_SCREEN_CTRL  = 8'h18;
  localparam logic [7:0]  REG_COLOR_SEL    = 8'hD9;
  localparam logic [7:0]  REG_GFX_CTRL     = 8'h20;
  localparam logic [7:0]  REG_POWER_MODE   = 8'h88;
  localparam logic [7:0]  REG_POWER_STATUS = 8'h89;
  localparam int          SCR_MONO_BIT     = 0;
  localparam int          GFX_BPP2_BIT     = 0;
  localparam int          GFX_PANEL480_BIT = 1;
  localparam int          GFX_WIDE640_BIT  = 2;
  localparam logic [4:0]  COLOR_SEL_RESET  = 5'h0F;

  // ----------------------------------------------------------------
  // power manager modes and refresh timing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PM_HIGH_SPEED = 3'h0,
    PM_DOZE       = 3'h1,
    PM_SLEEP      = 3'h2,
    PM_SUSPEND    = 3'h3,
    PM_OFF        = 3'h4
  } pm_mode_type;

  localparam int REFRESH_NS     = 15625;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int REFRESH_CYCLES = REFRESH_NS / CLK_PERIOD_NS;

endpackage

// [verilog/refresh_tick_if.sv]
// Purpose: carries the refresh tick from the divider to the sequencer
// Assumes: single clock domain
// Notes:   tick is one cycle wide
`timescale 1ns/100ps
`default_nettype none
interface refresh_tick_if;
  logic tick;
  modport source (output tick);
  modport sink   (input  tick);
endinterface
`default_nettype wire

// [verilog/refresh_divider.sv]
// Purpose: divides the core clock down to a one-cycle refresh tick
// Assumes: core clock at 250 MHz
// Notes:   period is a parameter so simulation can shorten it
`timescale 1ns/100ps
`default_nettype none
module refresh_divider
  import vidmap_pkg::*;
#(
  parameter int PERIOD = REFRESH_CYCLES
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         reset_n_i,
  // tick out
  refresh_tick_if.source    tick_if
);

  logic [31:0] count_q;

  // ------------------------------------------------------------
  // free running counter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q <= 32'h0;
    end else if (count_q == 32'(PERIOD - 1)) begin
      count_q <= 32'h0;
    end else begin
      count_q <= count_q + 32'h1;
    end
  end

  assign tick_if.tick = (count_q == 32'(PERIOD - 1));

endmodule
`default_nettype wire

// [verilog/video_memory_map_lcd_power.sv]
// Purpose: video SRAM decode, graphics pixel unpacking and LCD panel power sequencing
// Assumes: power manager mode and PLL states arrive as same-clock levels
// Notes:   reset pin is asynchronous; text mode and panel shift timing live elsewhere
//
// Summary of operation
// - both panel power enables are active low; 0 means supply on
// - during reset both enables are held at 1
// - logic enable on one refresh after reset, bias on the next refresh
// - sleep, or doze with video PLL stopped, turns bias enable off
// - logic enable stays on through sleep and doze, off only in suspend, off mode or forced suspend
// - waking from suspend, logic enable leads bias enable by one refresh
// - with low-speed and video PLLs both off, all LCD outputs are 0
// - forced suspend turns both enables off together
// - color-compatible mode decodes 0B8000h to 0BFFFFh
// - mono mode decodes 0B0000h to 0B7FFFh and aliases 0B8000h to 0BFFFFh
// - system address bits 14..0 go straight to SRAM address
// - no response outside 0B0000h to 0BFFFFh
// - 1 bpp: 8 pixels per byte, bit 7 leftmost, set bit lit
// - 1 bpp lit pixels use color select bits 4..0
// - 2 bpp: 4 pixels per byte, bits 7..6 leftmost
// - 320-column graphics on 640 panel doubles each pixel
// - rows alternate over 8 Kbyte banks
// - 640x200: two banks, rows of 80 bytes
// - 480x320: four banks, row r in bank r mod 4, rows of 60 bytes
// - 480x320 panel supports only 1 bpp
`timescale 1ns/100ps
`default_nettype none
module video_memory_map_lcd_power
  import vidmap_pkg::*;
#(
  parameter int REFRESH_PERIOD = REFRESH_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [7:0]  reg_rdata_o,
  // power manager state
  input  wire logic [2:0]  power_manager_mode_i,
  input  wire logic        video_pll_on_i,
  input  wire logic        low_speed_pll_on_i,
  // cpu video access
  input  wire logic [23:0] sys_addr_i,
  input  wire logic        sys_cycle_i,
  output logic             video_select_o,
  output logic      [14:0] video_sram_addr_o,
  // display fetch and pixels
  input  wire logic [8:0]  fetch_row_i,
  input  wire logic [6:0]  fetch_col_i,
  output logic      [14:0] fetch_addr_o,
  input  wire logic [7:0]  pixel_byte_i,
  input  wire logic        pixel_load_i,
  input  wire logic        pixel_step_i,
  output logic      [4:0]  pixel_color_o,
  output logic             pixel_valid_o,
  // panel power
  output logic             panel_logic_power_en_n_o,
  output logic             panel_bias_power_en_n_o,
  output logic             lcd_outputs_off_o
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // ------------------------------------------------------------
  // refresh tick
  // ------------------------------------------------------------
  refresh_tick_if rt ();
  refresh_divider #(.PERIOD(REFRESH_PERIOD)) u_div (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .tick_if    (rt.source)
  );
  logic tick;
  assign tick = rt.tick;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic       mono_q;
  logic [4:0] color_sel_q;
  logic       bpp2_q;
  logic       panel480_q;
  logic       wide640_q;
  logic       force_suspend_q;
  logic       bpp2_eff;

  // 2 bpp does not fit the SRAM on the 480-wide panel, so it is masked there
  assign bpp2_eff = bpp2_q && !panel480_q;

  // software configuration writes
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mono_q          <= 1'b0;
      color_sel_q     <= COLOR_SEL_RESET;
      bpp2_q          <= 1'b0;
      panel480_q      <= 1'b0;
      wide640_q       <= 1'b1;
      force_suspend_q <= 1'b0;
    end else if (reg_write_i) begin
      unique case (reg_addr_i)
        REG_SCREEN_CTRL: mono_q <= reg_wdata_i[SCR_MONO_BIT];
        REG_COLOR_SEL:   color_sel_q <= reg_wdata_i[4:0];
        REG_GFX_CTRL: begin
          bpp2_q     <= reg_wdata_i[GFX_BPP2_BIT];
          panel480_q <= reg_wdata_i[GFX_PANEL480_BIT];
          wide640_q  <= reg_wdata_i[GFX_WIDE640_BIT];
        end
        REG_POWER_MODE:  force_suspend_q <= reg_wdata_i[0];
        default: ;
      endcase
    end
  end

  // read data stands the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_read_i) begin
      unique case (reg_addr_i)
        REG_SCREEN_CTRL:  reg_rdata_o <= {7'h00, mono_q};
        REG_COLOR_SEL:    reg_rdata_o <= {3'h0, color_sel_q};
        REG_GFX_CTRL:     reg_rdata_o <= {5'h00, wide640_q, panel480_q, bpp2_q};
        REG_POWER_MODE:   reg_rdata_o <= {7'h00, force_suspend_q};
        REG_POWER_STATUS: reg_rdata_o <= {5'h00, lcd_outputs_off_o,
                                          panel_bias_power_en_n_o,
                                          panel_logic_power_en_n_o};
        default:          reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // cpu address decode
  // ------------------------------------------------------------
  logic hit;
  // color window always decodes; mono adds the low window and keeps the alias
  assign hit = sys_cycle_i &&
               (in_range(sys_addr_i, COLOR_WIN_BASE, COLOR_WIN_LAST) ||
                (mono_q && in_range(sys_addr_i, MONO_WIN_BASE, MONO_WIN_LAST)));

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      video_select_o    <= 1'b0;
      video_sram_addr_o <= 15'h0;
    end else begin
      video_select_o    <= hit;
      video_sram_addr_o <= sys_addr_i[SRAM_ADDR_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // display fetch address
  // ------------------------------------------------------------
  logic [14:0] bank_off;
  logic [14:0] row_in_bank;
  logic [14:0] fetch_d;
  always_comb begin
    bank_off    = 15'h0;
    row_in_bank = 15'h0;
    if (panel480_q) begin
      bank_off    = BANK_SIZE * 15'(fetch_row_i[1:0]);
      row_in_bank = 15'(fetch_row_i[8:2]) * 15'(BYTES_ROW_480);
    end else begin
      bank_off    = BANK_SIZE * 15'(fetch_row_i[0]);
      row_in_bank = 15'(fetch_row_i[8:1]) * 15'(BYTES_ROW_640);
    end
    fetch_d = bank_off + row_in_bank + 15'(fetch_col_i);
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fetch_addr_o <= 15'h0;
    end else begin
      fetch_addr_o <= fetch_d;
    end
  end

  // ------------------------------------------------------------
  // pixel unpacking
  // ------------------------------------------------------------
  logic [7:0] shift_q;
  logic [3:0] left_q;   // physical pixels still to show from this byte
  logic       dup_q;    // second copy of a doubled pixel
  logic       doubling;
  assign doubling = bpp2_eff && wide640_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_q <= 8'h00;
      left_q  <= 4'h0;
      dup_q   <= 1'b0;
    end else if (pixel_load_i) begin
      shift_q <= pixel_byte_i;
      left_q  <= bpp2_eff ? (doubling ? 4'h8 : 4'h4) : 4'h8;
      dup_q   <= 1'b0;
    end else if (pixel_step_i && left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
      if (doubling && !dup_q) begin
        dup_q <= 1'b1;
      end else begin
        dup_q   <= 1'b0;
        shift_q <= bpp2_eff ? {shift_q[5:0], 2'b00} : {shift_q[6:0], 1'b0};
      end
    end
  end

  // msb end is always the leftmost pixel
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pixel_color_o <= 5'h00;
      pixel_valid_o <= 1'b0;
    end else if (lcd_outputs_off_o) begin
      pixel_color_o <= 5'h00;
      pixel_valid_o <= 1'b0;
    end else begin
      pixel_valid_o <= (left_q != 4'h0);
      if (bpp2_eff) begin
        pixel_color_o <= {3'h0, shift_q[7:6]};
      end else begin
        pixel_color_o <= shift_q[7] ? color_sel_q : 5'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // panel power sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_OFF, PWR_LOGIC_WAIT, PWR_BIAS_WAIT, PWR_ON, PWR_BIAS_DOWN
  } pwr_state_type;
  pwr_state_type pwr_q;

  logic in_suspend;
  logic bias_drop;
  assign in_suspend = (power_manager_mode_i >= 3'(PM_SUSPEND)) || force_suspend_q;
  assign bias_drop  = (power_manager_mode_i == 3'(PM_SLEEP)) ||
                      (power_manager_mode_i == 3'(PM_DOZE) && !video_pll_on_i);

  // state stepping happens on refresh ticks, except suspend, bias drop and arming from off, which act at once
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwr_q <= PWR_OFF;
    end else if (in_suspend) begin
      pwr_q <= PWR_OFF;
    end else if (bias_drop && (pwr_q == PWR_ON || pwr_q == PWR_BIAS_WAIT)) begin
      pwr_q <= PWR_BIAS_DOWN;
    end else if (pwr_q == PWR_OFF) begin
      // arm at once, so the very next refresh tick lights the logic supply
      pwr_q <= PWR_LOGIC_WAIT;
    end else if (tick) begin
      unique case (pwr_q)
        PWR_OFF:        pwr_q <= PWR_LOGIC_WAIT;
        PWR_LOGIC_WAIT: pwr_q <= PWR_BIAS_WAIT;
        PWR_BIAS_WAIT:  pwr_q <= PWR_ON;
        PWR_ON:         pwr_q <= PWR_ON;
        // logic stayed on throughout, so bias may return on the next tick
        PWR_BIAS_DOWN:  pwr_q <= bias_drop ? PWR_BIAS_DOWN : PWR_ON;
      endcase
    end
  end

  // enables are active low: 0 switches the supply on
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      panel_logic_power_en_n_o <= 1'b1;
      panel_bias_power_en_n_o  <= 1'b1;
      lcd_outputs_off_o        <= 1'b1;
    end else begin
      panel_logic_power_en_n_o <= !(pwr_q == PWR_BIAS_WAIT || pwr_q == PWR_ON ||
                                    pwr_q == PWR_BIAS_DOWN) || in_suspend;
      panel_bias_power_en_n_o  <= !(pwr_q == PWR_ON) || in_suspend || bias_drop;
      lcd_outputs_off_o        <= !low_speed_pll_on_i && !video_pll_on_i;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // power sequencing
  a_bias_after_logic: assert property (
    $fell(panel_bias_power_en_n_o) |-> !panel_logic_power_en_n_o &&
    $past(!panel_logic_power_en_n_o)) else $error("bias on before logic");
  a_suspend_both_off: assert property (
    in_suspend |=> panel_logic_power_en_n_o && panel_bias_power_en_n_o)
    else $error("suspend left a supply on");
  a_sleep_bias_off: assert property (
    bias_drop |=> panel_bias_power_en_n_o) else $error("bias on in sleep");
  a_sleep_logic_on: assert property (
    (pwr_q == PWR_BIAS_DOWN && !in_suspend) |=> !panel_logic_power_en_n_o)
    else $error("logic dropped in sleep");
  a_logic_tick_step: assert property (
    $fell(panel_logic_power_en_n_o) |-> $past(tick, 2)) else $error("logic on off tick");
  // pixel path
  a_lcd_forced_zero: assert property (
    lcd_outputs_off_o |=> pixel_color_o == 5'h00) else $error("lcd data not zero");
  a_one_bpp_480: assert property (
    ($past(panel480_q) && !$past(lcd_outputs_off_o)) |->
    (pixel_color_o == 5'h00 || pixel_color_o == $past(color_sel_q)))
    else $error("2 bpp on 480");
  // cpu decode
  a_decode_range: assert property (
    video_select_o |-> $past(sys_addr_i[23:16]) == 8'h0B) else $error("decode out of range");
  a_color_window: assert property (
    (sys_cycle_i && !mono_q && sys_addr_i[23:15] == 9'h016) |=> !video_select_o)
    else $error("mono window hit in color mode");
  a_mono_alias: assert property (
    (sys_cycle_i && mono_q && sys_addr_i[23:16] == 8'h0B) |=> video_select_o)
    else $error("mono window or alias missed");
  a_sram_passthru: assert property (
    video_sram_addr_o == $past(sys_addr_i[14:0])) else $error("address bits altered");
  // display fetch
  a_fetch_bank_640: assert property (
    (!panel480_q && fetch_row_i < 9'h0C8) |=>
    fetch_addr_o[14:13] == {1'b0, $past(fetch_row_i[0])}) else $error("640 bank wrong");
  a_fetch_bank_480: assert property (
    panel480_q |=> fetch_addr_o[14:13] == $past(fetch_row_i[1:0]))
    else $error("480 bank wrong");

  // main scenarios the bench is expected to reach
  c_power_up:  cover property (pwr_q == PWR_BIAS_WAIT ##1 pwr_q == PWR_ON);
  c_wake:      cover property (pwr_q == PWR_LOGIC_WAIT ##1 pwr_q == PWR_BIAS_WAIT);
  c_sleep:     cover property (pwr_q == PWR_BIAS_DOWN);
  c_mono_hit:  cover property (mono_q && video_select_o);
  c_doubling:  cover property (doubling && pixel_valid_o);

endmodule
`default_nettype wire

// [tb/panel_supply_model.sv]
// Purpose: behavioural panel supplies switched by the two active-low enables
// Assumes: supplies follow their enables one clock later
// Notes:   flags a sticky fault if high voltage is ever present without logic supply
`timescale 1ns/100ps
`default_nettype none
module panel_supply_model (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  // enables from the device
  input  wire logic logic_en_n_i,
  input  wire logic bias_en_n_i,
  // supply state
  output var  logic logic_on_o,
  output var  logic bias_on_o,
  output var  logic order_fault_o
);
  // ------------------------------------------------------------
  // supply switches
  // ------------------------------------------------------------
  // a 0 on an enable switches its supply on
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      logic_on_o <= 1'b0;
      bias_on_o  <= 1'b0;
    end else begin
      logic_on_o <= !logic_en_n_i;
      bias_on_o  <= !bias_en_n_i;
    end
  end
  // bias without logic supply damages a real panel, so remember it
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) order_fault_o <= 1'b0;
    else if (bias_on_o && !logic_on_o) order_fault_o <= 1'b1;
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for video decode, fetch, pixels and panel power
// Assumes: refresh period shortened to 8 cycles
// Notes:   random stimulus from a fixed seed with boundary cases mixed in
`timescale 1ns/100ps
`default_nettype none
module tb;
  import vidmap_pkg::*;
  localparam int PER = 8;
  logic core_clk_i = 0, reset_n_i = 0, reg_write_i = 0, reg_read_i = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, pixel_byte_i = 8'h00;
  logic [2:0] power_manager_mode_i = 3'h0;
  logic video_pll_on_i = 1, low_speed_pll_on_i = 1, sys_cycle_i = 1;
  logic [23:0] sys_addr_i = 24'h000000;
  logic video_select_o, pixel_load_i = 0, pixel_step_i = 0, pixel_valid_o;
  logic [14:0] video_sram_addr_o, fetch_addr_o;
  logic [8:0] fetch_row_i = 9'h000;
  logic [6:0] fetch_col_i = 7'h00;
  logic [4:0] pixel_color_o;
  logic panel_logic_power_en_n_o, panel_bias_power_en_n_o, lcd_outputs_off_o;
  logic logic_on, bias_on, order_fault;
  int failures = 0, checks = 0, seed = 98, n, i, r, c;
  logic [23:0] a;
  logic [7:0] d, b;
  logic [23:0] corner [6] = '{24'h0AFFFF, 24'h0B0000, 24'h0B7FFF, 24'h0B8000, 24'h0BFFFF, 24'h0C0000};

  video_memory_map_lcd_power #(.REFRESH_PERIOD(PER)) uut (.*);
  panel_supply_model far (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .logic_en_n_i(panel_logic_power_en_n_o), .bias_en_n_i(panel_bias_power_en_n_o),
    .logic_on_o(logic_on), .bias_on_o(bias_on), .order_fault_o(order_fault));

  // clock: 4 ns period
  always #2 core_clk_i = ~core_clk_i;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge core_clk_i);
    reg_addr_i <= ad; reg_wdata_i <= wd; reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] q);
    @(posedge core_clk_i);
    reg_addr_i <= ad; reg_read_i <= 1'b1;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 q = reg_rdata_o;
  endtask
  function automatic logic pin(input int s);
    return s == 0 ? panel_logic_power_en_n_o : s == 1 ? panel_bias_power_en_n_o : lcd_outputs_off_o;
  endfunction
  // bounded wait: n returns the cycles taken, 60 means it never came
  task automatic wait_pin(input int s, input logic v, output int cnt);
    cnt = 0;
    while (pin(s) !== v && cnt < 60) begin
      @(posedge core_clk_i); #1 cnt++;
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  function automatic logic [14:0] fexp(input int row, input int col, input logic p480);
    if (p480) return 15'(row % 4 * 'h2000 + row / 4 * 60 + col);
    return 15'(row % 2 * 'h2000 + row / 2 * 80 + col);
  endfunction
  function automatic logic hit(input logic [23:0] ad, input logic mono);
    return (ad >= 24'h0B8000 && ad <= 24'h0BFFFF) || (mono && ad >= 24'h0B0000 && ad <= 24'h0B7FFF);
  endfunction
  // expected colour of the pixel held in byte bit ix; two means 2 bits per pixel
  function automatic logic [4:0] pexp(input logic [7:0] pb, input int ix, input logic [4:0] cs,
                                      input logic two);
    if (two) return {3'h0, pb[2 * (ix / 2) +: 2]};
    return pb[ix] ? cs : 5'h00;
  endfunction

  // watchdog well beyond the expected run length
  initial begin
    #40000;
    failures++;
    close_out();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    idle(3);
    chk("logic_en_rst", 1, panel_logic_power_en_n_o);
    chk("bias_en_rst", 1, panel_bias_power_en_n_o);
    reset_n_i <= 1'b1;
    wait_pin(0, 1'b0, n);
    chk("logic_on_lat", 1, n >= PER - 2 && n <= PER + 3);
    chk("bias_still_off", 1, panel_bias_power_en_n_o);
    wait_pin(1, 1'b0, n);
    chk("bias_on_gap", 1, n >= PER - 2 && n <= PER + 3);
    $display("power-up sequence done");
    rd(REG_COLOR_SEL, d); chk("color_sel_rst", 8'h0F, d);
    rd(REG_GFX_CTRL, d); chk("gfx_rst", 8'h04, d);
    wr(8'h55, 8'hA5); rd(8'h55, d); chk("unmapped", 8'h00, d);
    $display("register test done");
    for (int m = 0; m < 2; m++) begin
      wr(REG_SCREEN_CTRL, 8'(m));
      for (i = 0; i < 46; i++) begin
        a = i < 6 ? corner[i] : {8'h0A + 8'($unsigned($random(seed)) % 3), 16'($random(seed))};
        @(posedge core_clk_i) sys_addr_i <= a;
        idle(1);
        chk("video_select", hit(a, m[0]), video_select_o);
        chk("sram_addr", a[14:0], video_sram_addr_o);
      end
    end
    @(posedge core_clk_i); sys_cycle_i <= 1'b0; sys_addr_i <= 24'h0B8000;
    idle(1);
    chk("idle_no_select", 0, video_select_o);
    sys_cycle_i <= 1'b1;
    $display("decode test done");
    for (int p = 0; p < 2; p++) begin
      wr(REG_GFX_CTRL, p ? 8'h02 : 8'h04);
      for (i = 0; i < 30; i++) begin
        r = i == 0 ? (p ? 319 : 199) : $unsigned($random(seed)) % (p ? 320 : 200);
        c = i == 0 ? (p ? 59 : 79) : $unsigned($random(seed)) % (p ? 60 : 80);
        @(posedge core_clk_i);
        fetch_row_i <= 9'(r); fetch_col_i <= 7'(c);
        idle(1);
        chk("fetch_addr", fexp(r, c, p[0]), fetch_addr_o);
      end
    end
    $display("fetch test done");
    for (int k = 0; k < 6; k++) begin
      d = 8'($random(seed)) & 8'h1F;
      b = k == 0 ? 8'h81 : 8'($random(seed));
      wr(REG_GFX_CTRL, k < 4 ? 8'h04 : 8'h05);
      wr(REG_COLOR_SEL, d);
      rd(REG_COLOR_SEL, a[7:0]); chk("color_sel_rb", d, a[7:0]);
      @(posedge core_clk_i); pixel_byte_i <= b; pixel_load_i <= 1'b1;
      @(posedge core_clk_i); pixel_load_i <= 1'b0; pixel_step_i <= 1'b1;
      // the colour is registered, so the first pixel shows one edge after the load
      for (i = 7; i >= 0; i--) begin
        @(posedge core_clk_i);
        #1 chk("pixel_color", pexp(b, i, d[4:0], k > 3), pixel_color_o);
        chk("pixel_valid", 1, pixel_valid_o);
      end
      pixel_step_i <= 1'b0;
      idle(1);
      chk("pixel_done", 0, pixel_valid_o);
    end
    $display("pixel test done");
    for (int m = 0; m < 3; m++) begin
      @(posedge core_clk_i);
      power_manager_mode_i <= m == 0 ? PM_SLEEP : PM_DOZE;
      video_pll_on_i <= m == 2;
      idle(3);
      chk("bias_off_low_pwr", m < 2, panel_bias_power_en_n_o);
      idle(2 * PER);
      chk("logic_kept_on", 0, panel_logic_power_en_n_o);
      @(posedge core_clk_i); power_manager_mode_i <= PM_HIGH_SPEED; video_pll_on_i <= 1'b1;
      wait_pin(1, 1'b0, n); chk("bias_back", 1, n <= PER + 3);
    end
    @(posedge core_clk_i); low_speed_pll_on_i <= 1'b0; video_pll_on_i <= 1'b0;
    wait_pin(2, 1'b1, n); chk("lcd_forced_off", 1, n <= 3);
    @(posedge core_clk_i); power_manager_mode_i <= PM_SUSPEND;
    wait_pin(0, 1'b1, n); chk("logic_off_suspend", 1, n <= 3);
    @(posedge core_clk_i); power_manager_mode_i <= PM_HIGH_SPEED;
    low_speed_pll_on_i <= 1'b1; video_pll_on_i <= 1'b1;
    wait_pin(2, 1'b0, n); chk("lcd_released", 1, n <= 3);
    wait_pin(0, 1'b0, n); chk("wake_logic", 1, n <= PER + 3);
    chk("wake_bias_later", 1, panel_bias_power_en_n_o);
    wait_pin(1, 1'b0, n); chk("wake_bias_gap", 1, n >= PER - 2 && n <= PER + 3);
    wr(REG_POWER_MODE, 8'h01);
    for (i = 0; i < 4; i++) begin
      #1 chk("force_together", panel_logic_power_en_n_o, panel_bias_power_en_n_o);
      @(posedge core_clk_i);
    end
    #1 chk("force_off", 1, panel_logic_power_en_n_o);
    wr(REG_POWER_MODE, 8'h00);
    wait_pin(1, 1'b0, n); wait_pin(1, 1'b0, n);
    chk("recover_bias", 0, panel_bias_power_en_n_o);
    chk("supply_order", 0, order_fault);
    $display("power test done");
    close_out();
  end
endmodule
`default_nettype wire
